/* design/usb_pins_pkg.sv */
// Constants, field layout and register map for the USB status and reset pin block
package usb_pins_pkg;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned EXT_RESET_MIN_NS = 15000;
  localparam int unsigned EXT_RESET_MIN_CYC = (EXT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_DRIVE_NS = 20000;
  localparam int unsigned RESET_DRIVE_CYC = RESET_DRIVE_NS / CLK_PERIOD_NS;
  localparam int unsigned RESET_BLANK_CYC = 4;

  // Register byte offsets
  localparam logic [7:0] STAT1_CFG_OFS = 8'h00;
  localparam logic [7:0] STAT2_CFG_OFS = 8'h04;
  localparam logic [7:0] POWER_CFG_OFS = 8'h08;
  localparam logic [7:0] PIN_FUNC_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] CONTROL_OFS = 8'h14;

  // Status pin condition select
  typedef enum logic [1:0] {
    SEL_BUS_RESET = 2'b00,
    SEL_SUSPEND = 2'b01,
    SEL_POWER = 2'b10
  } stat_sel_t;

  // Pin seven function
  typedef enum logic [1:0] {
    G7_GPIO = 2'b00,
    G7_RING = 2'b01,
    G7_WAKE = 2'b10
  } g7_mode_t;

  // Status pin config fields and reset values
  localparam int unsigned STAT_POL_BIT = 0;
  localparam int unsigned STAT_SEL_LSB = 1;
  localparam logic STAT1_POL_RST = 1'b1;
  localparam logic STAT2_POL_RST = 1'b0;
  localparam stat_sel_t STAT_SEL_RST = SEL_SUSPEND;

  // Power config fields
  localparam int unsigned MAXPWR_LSB = 0;
  localparam int unsigned SELF_PWR_BIT = 8;
  localparam logic [7:0] MAXPWR_RST = 8'h32;
  localparam logic [7:0] LOW_POWER_LIMIT = 8'h32;
  localparam logic SELF_PWR_RST = 1'b0;

  // Pin function fields
  localparam int unsigned G9_MODEM_BIT = 0;
  localparam int unsigned G8_MODEM_BIT = 1;
  localparam int unsigned G7_MODE_LSB = 2;
  localparam int unsigned G9_DIR_BIT = 4;
  localparam int unsigned G8_DIR_BIT = 5;
  localparam int unsigned G7_DIR_BIT = 6;
  localparam int unsigned G9_OUT_BIT = 7;
  localparam int unsigned G8_OUT_BIT = 8;
  localparam int unsigned G7_OUT_BIT = 9;
  localparam int unsigned G7_PULL_BIT = 10;
  localparam logic [10:0] PIN_FUNC_RST = 11'h430;

  // Status register bits
  localparam int unsigned ST_BUSRST_BIT = 0;
  localparam int unsigned ST_SUSP_BIT = 1;
  localparam int unsigned ST_CONF_BIT = 2;
  localparam int unsigned ST_VBUS_BIT = 3;
  localparam int unsigned ST_PIN_LSB = 4;
  localparam int unsigned ST_STAT1_BIT = 7;
  localparam int unsigned ST_STAT2_BIT = 8;
  localparam int unsigned ST_RSTLINE_BIT = 9;

  // Control and bus answers
  localparam int unsigned SOFT_RST_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* design/status_pin_drive.sv */
// Condition select, polarity and open-drain drive of one USB status pin
`timescale 1ns/1ps
`default_nettype none
module status_pin_drive (
  input wire logic i_clk,
  input wire logic i_rst,
  // Configuration
  input wire logic i_pol,
  input wire logic [1:0] i_sel,
  input wire logic i_high_power,
  // Device state
  input wire logic i_bus_reset,
  input wire logic i_suspend,
  input wire logic i_configured,
  // Pin drive
  output logic o_oe,
  output logic o_active
);
  logic cond;

  // Selected condition
  always_comb begin
    case (usb_pins_pkg::stat_sel_t'(i_sel))
      usb_pins_pkg::SEL_BUS_RESET: cond = i_bus_reset;
      usb_pins_pkg::SEL_SUSPEND: cond = i_suspend;
      usb_pins_pkg::SEL_POWER: cond = i_suspend | (i_high_power & ~i_configured);
      default: cond = 1'b0;
    endcase
  end

  // Polarity before the driver; low level pulls the pin
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_active <= 1'b0;
      o_oe <= i_pol;
    end else begin
      o_active <= cond;
      o_oe <= ~(i_pol ? cond : ~cond);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_suspend_sel: assert property ((i_sel == 2'b01) && i_suspend |=> o_active)
    else $error("status not asserted in suspend");
  a_busrst_sel: assert property ((i_sel == 2'b00) && i_bus_reset |=> o_active)
    else $error("status not asserted in bus reset");
  a_power_low: assert property ((i_sel == 2'b10) && !i_high_power && !i_suspend |=> !o_active)
    else $error("low power status asserted outside suspend");
  a_power_high: assert property ((i_sel == 2'b10) && i_high_power && !i_configured |=> o_active)
    else $error("high power status not asserted unconfigured");
  a_open_drain: assert property (o_oe == (o_active != $past(i_pol)))
    else $error("open drain level wrong for polarity");
  c_power_assert: cover property ((i_sel == 2'b10) && o_active && !i_suspend);
endmodule
`default_nettype wire

/* design/usb_status_reset_pins.sv */
// Reset line, status pins, pull-up control and modem pin defaults with AXI4-Lite registers
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module usb_status_reset_pins #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // USB core state
  input wire logic I_USB_BUS_RESET,
  input wire logic I_SUSPENDED,
  input wire logic I_CONFIGURED,
  output logic O_CORE_RESET,
  // Reset line, open drain
  input wire logic I_RESET_LINE_N,
  output logic O_RESET_LINE_OE,
  // Status pins, open drain
  output logic O_BUS_STATUS_OE,
  output logic O_SECOND_BUS_STATUS_OE,
  // Bus power and pull-up
  input wire logic I_BUS_POWER_SENSE,
  output logic O_DP_PULLUP_EN,
  // Pin nine
  input wire logic I_GPIO_NINE,
  output logic O_GPIO_NINE,
  output logic O_GPIO_NINE_OE,
  output logic O_SET_READY_N,
  // Pin eight
  input wire logic I_GPIO_EIGHT,
  output logic O_GPIO_EIGHT,
  output logic O_GPIO_EIGHT_OE,
  input wire logic I_TERMINAL_READY_N,
  // Pin seven
  input wire logic I_GPIO_SEVEN,
  output logic O_GPIO_SEVEN,
  output logic O_GPIO_SEVEN_OE,
  output logic O_GPIO_SEVEN_PULLUP,
  output logic O_RING_N,
  output logic O_REMOTE_WAKE_N
);
  localparam logic [15:0] DRIVE_CYC = 16'(usb_pins_pkg::RESET_DRIVE_CYC);
  localparam logic [15:0] BLANK_CYC = 16'(usb_pins_pkg::RESET_BLANK_CYC);
  localparam logic [15:0] EXT_MIN = 16'(usb_pins_pkg::EXT_RESET_MIN_CYC);

  logic [4:0] sync1_r, sync2_r;
  logic [15:0] drive_cnt_r, blank_cnt_r, ext_cnt_r;
  logic ext_det_r, soft_rst_r, reset_oe_r, driving, cfg_rst, stat_rst;
  logic stat1_pol_r, stat2_pol_r, high_power;
  logic [1:0] stat1_sel_r, stat2_sel_r;
  logic [7:0] max_pwr_r;
  logic self_pwr_r;
  logic [10:0] pin_func_r;
  logic stat1_active, stat2_active;
  logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r, rd_mux;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_exec;
  logic [1:0] g7_mode;

  // Two-flop synchronisers: reset line, VBUS, pins seven to nine
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      sync1_r <= 5'h1D;
      sync2_r <= 5'h1D;
    end else begin
      sync1_r <= {I_GPIO_NINE, I_GPIO_EIGHT, I_GPIO_SEVEN, I_BUS_POWER_SENSE, I_RESET_LINE_N};
      sync2_r <= sync1_r;
    end
  end

  assign driving = drive_cnt_r != 16'h0000;
  assign cfg_rst = I_RESET | reset_oe_r;
  assign stat_rst = I_RESET | soft_rst_r;

  // Reset drive stretch from every reset source
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      drive_cnt_r <= DRIVE_CYC;
    end else if (soft_rst_r | I_USB_BUS_RESET | ext_det_r) begin
      drive_cnt_r <= DRIVE_CYC;
    end else if (driving) begin
      drive_cnt_r <= drive_cnt_r - 16'h0001;
    end
  end

  // Blanking after release, while the weak pull-up restores the line
  always_ff @(posedge I_MCLK) begin
    if (I_RESET || driving) begin
      blank_cnt_r <= BLANK_CYC;
    end else if (blank_cnt_r != 16'h0000) begin
      blank_cnt_r <= blank_cnt_r - 16'h0001;
    end
  end

  // External low pulse width filter on the reset line
  always_ff @(posedge I_MCLK) begin
    if (I_RESET || driving || blank_cnt_r != 16'h0000 || sync2_r[0]) begin
      ext_cnt_r <= 16'h0000;
      ext_det_r <= 1'b0;
    end else begin
      ext_det_r <= ext_cnt_r == EXT_MIN - 16'h0001;
      if (ext_cnt_r != EXT_MIN) begin
        ext_cnt_r <= ext_cnt_r + 16'h0001;
      end
    end
  end

  // Open-drain reset line and core reset
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      reset_oe_r <= 1'b1;
    end else begin
      reset_oe_r <= driving | I_USB_BUS_RESET;
    end
  end
  assign O_RESET_LINE_OE = reset_oe_r;
  assign O_CORE_RESET = reset_oe_r;

  // Software reset pulse
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_exec && awaddr_r == usb_pins_pkg::CONTROL_OFS[ADDR_W-1:0]
        && wstrb_r[0] && wdata_r[usb_pins_pkg::SOFT_RST_BIT];
    end
  end

  // Write address and data capture
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      if (I_AWVALID && awready_r) begin
        aw_got_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r <= I_AWADDR;
      end else if (wr_exec) begin
        aw_got_r <= 1'b0;
      end
      if (I_WVALID && wready_r) begin
        w_got_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= I_WDATA;
        wstrb_r <= I_WSTRB;
      end else if (wr_exec) begin
        w_got_r <= 1'b0;
      end
      if (bvalid_r && I_BREADY) begin
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end
  assign wr_exec = aw_got_r & w_got_r & ~bvalid_r;

  // Write response
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      bvalid_r <= 1'b0;
      bresp_r <= usb_pins_pkg::RESP_OKAY;
    end else if (wr_exec) begin
      bvalid_r <= 1'b1;
      bresp_r <= (awaddr_r[ADDR_W-1:0] > usb_pins_pkg::CONTROL_OFS[ADDR_W-1:0]
        || awaddr_r[1:0] != 2'b00) ? usb_pins_pkg::RESP_SLVERR : usb_pins_pkg::RESP_OKAY;
    end else if (bvalid_r && I_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // Status pin and power configuration, kept across bus reset
  always_ff @(posedge I_MCLK) begin
    if (stat_rst) begin
      stat1_pol_r <= usb_pins_pkg::STAT1_POL_RST;
      stat1_sel_r <= usb_pins_pkg::STAT_SEL_RST;
      stat2_pol_r <= usb_pins_pkg::STAT2_POL_RST;
      stat2_sel_r <= usb_pins_pkg::STAT_SEL_RST;
      max_pwr_r <= usb_pins_pkg::MAXPWR_RST;
      self_pwr_r <= usb_pins_pkg::SELF_PWR_RST;
    end else if (wr_exec) begin
      if (awaddr_r == usb_pins_pkg::STAT1_CFG_OFS[ADDR_W-1:0] && wstrb_r[0]) begin
        stat1_pol_r <= wdata_r[usb_pins_pkg::STAT_POL_BIT];
        stat1_sel_r <= wdata_r[usb_pins_pkg::STAT_SEL_LSB +: 2];
      end
      if (awaddr_r == usb_pins_pkg::STAT2_CFG_OFS[ADDR_W-1:0] && wstrb_r[0]) begin
        stat2_pol_r <= wdata_r[usb_pins_pkg::STAT_POL_BIT];
        stat2_sel_r <= wdata_r[usb_pins_pkg::STAT_SEL_LSB +: 2];
      end
      if (awaddr_r == usb_pins_pkg::POWER_CFG_OFS[ADDR_W-1:0]) begin
        if (wstrb_r[0]) max_pwr_r <= wdata_r[usb_pins_pkg::MAXPWR_LSB +: 8];
        if (wstrb_r[1]) self_pwr_r <= wdata_r[usb_pins_pkg::SELF_PWR_BIT];
      end
    end
  end

  // Pin function register, lost on any device reset
  always_ff @(posedge I_MCLK) begin
    if (cfg_rst) begin
      pin_func_r <= usb_pins_pkg::PIN_FUNC_RST;
    end else if (wr_exec && awaddr_r == usb_pins_pkg::PIN_FUNC_OFS[ADDR_W-1:0]) begin
      if (wstrb_r[0]) pin_func_r[7:0] <= wdata_r[7:0];
      if (wstrb_r[1]) pin_func_r[10:8] <= wdata_r[10:8];
    end
  end

  // Read mux
  always_comb begin
    rd_mux = 32'h00000000;
    case (I_ARADDR)
      usb_pins_pkg::STAT1_CFG_OFS[ADDR_W-1:0]: rd_mux[2:0] = {stat1_sel_r, stat1_pol_r};
      usb_pins_pkg::STAT2_CFG_OFS[ADDR_W-1:0]: rd_mux[2:0] = {stat2_sel_r, stat2_pol_r};
      usb_pins_pkg::POWER_CFG_OFS[ADDR_W-1:0]: rd_mux[8:0] = {self_pwr_r, max_pwr_r};
      usb_pins_pkg::PIN_FUNC_OFS[ADDR_W-1:0]: rd_mux[10:0] = pin_func_r;
      usb_pins_pkg::STATUS_OFS[ADDR_W-1:0]: begin
        rd_mux[usb_pins_pkg::ST_BUSRST_BIT] = I_USB_BUS_RESET;
        rd_mux[usb_pins_pkg::ST_SUSP_BIT] = I_SUSPENDED;
        rd_mux[usb_pins_pkg::ST_CONF_BIT] = I_CONFIGURED;
        rd_mux[usb_pins_pkg::ST_VBUS_BIT] = sync2_r[1];
        rd_mux[usb_pins_pkg::ST_PIN_LSB +: 3] = sync2_r[4:2];
        rd_mux[usb_pins_pkg::ST_STAT1_BIT] = stat1_active;
        rd_mux[usb_pins_pkg::ST_STAT2_BIT] = stat2_active;
        rd_mux[usb_pins_pkg::ST_RSTLINE_BIT] = sync2_r[0];
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read channel
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= usb_pins_pkg::RESP_OKAY;
    end else if (I_ARVALID && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= (I_ARADDR > usb_pins_pkg::CONTROL_OFS[ADDR_W-1:0] || I_ARADDR[1:0] != 2'b00)
        ? usb_pins_pkg::RESP_SLVERR : usb_pins_pkg::RESP_OKAY;
    end else if (rvalid_r && I_RREADY) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign O_AWREADY = awready_r;
  assign O_WREADY = wready_r;
  assign O_BVALID = bvalid_r;
  assign O_BRESP = bresp_r;
  assign O_ARREADY = arready_r;
  assign O_RVALID = rvalid_r;
  assign O_RDATA = rdata_r;
  assign O_RRESP = rresp_r;

  assign high_power = max_pwr_r > usb_pins_pkg::LOW_POWER_LIMIT;

  // First status pin
  status_pin_drive u_stat1 (
    .i_clk(I_MCLK),
    .i_rst(I_RESET),
    .i_pol(stat1_pol_r),
    .i_sel(stat1_sel_r),
    .i_high_power(high_power),
    .i_bus_reset(I_USB_BUS_RESET),
    .i_suspend(I_SUSPENDED),
    .i_configured(I_CONFIGURED),
    .o_oe(O_BUS_STATUS_OE),
    .o_active(stat1_active)
  );

  // Second status pin
  status_pin_drive u_stat2 (
    .i_clk(I_MCLK),
    .i_rst(I_RESET),
    .i_pol(stat2_pol_r),
    .i_sel(stat2_sel_r),
    .i_high_power(high_power),
    .i_bus_reset(I_USB_BUS_RESET),
    .i_suspend(I_SUSPENDED),
    .i_configured(I_CONFIGURED),
    .o_oe(O_SECOND_BUS_STATUS_OE),
    .o_active(stat2_active)
  );

  // Data-plus pull-up from Bus_power_sense
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      O_DP_PULLUP_EN <= 1'b0;
    end else begin
      O_DP_PULLUP_EN <= ~(self_pwr_r & ~sync2_r[1]);
    end
  end

  assign g7_mode = pin_func_r[usb_pins_pkg::G7_MODE_LSB +: 2];

  // Modem and GPIO pin drivers
  always_ff @(posedge I_MCLK) begin
    if (cfg_rst) begin
      O_GPIO_NINE <= 1'b0;
      O_GPIO_NINE_OE <= 1'b1;
      O_SET_READY_N <= 1'b1;
      O_GPIO_EIGHT <= 1'b0;
      O_GPIO_EIGHT_OE <= 1'b1;
      O_GPIO_SEVEN <= 1'b0;
      O_GPIO_SEVEN_OE <= 1'b0;
      O_GPIO_SEVEN_PULLUP <= 1'b1;
      O_RING_N <= 1'b1;
      O_REMOTE_WAKE_N <= 1'b1;
    end else begin
      O_GPIO_NINE <= pin_func_r[usb_pins_pkg::G9_OUT_BIT];
      O_GPIO_NINE_OE <= ~pin_func_r[usb_pins_pkg::G9_MODEM_BIT]
        & pin_func_r[usb_pins_pkg::G9_DIR_BIT];
      O_SET_READY_N <= pin_func_r[usb_pins_pkg::G9_MODEM_BIT] ? sync2_r[4] : 1'b1;
      O_GPIO_EIGHT <= pin_func_r[usb_pins_pkg::G8_MODEM_BIT] ? I_TERMINAL_READY_N
        : pin_func_r[usb_pins_pkg::G8_OUT_BIT];
      O_GPIO_EIGHT_OE <= pin_func_r[usb_pins_pkg::G8_MODEM_BIT]
        | pin_func_r[usb_pins_pkg::G8_DIR_BIT];
      O_GPIO_SEVEN <= pin_func_r[usb_pins_pkg::G7_OUT_BIT];
      O_GPIO_SEVEN_OE <= (g7_mode == usb_pins_pkg::G7_GPIO)
        & pin_func_r[usb_pins_pkg::G7_DIR_BIT];
      O_GPIO_SEVEN_PULLUP <= pin_func_r[usb_pins_pkg::G7_PULL_BIT];
      O_RING_N <= (g7_mode == usb_pins_pkg::G7_RING) ? sync2_r[2] : 1'b1;
      O_REMOTE_WAKE_N <= (g7_mode == usb_pins_pkg::G7_WAKE) ? sync2_r[2] : 1'b1;
    end
  end

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);

  a_por_drive: assert property ($fell(I_RESET) |-> O_RESET_LINE_OE && O_CORE_RESET)
    else $error("reset line not driven after power-on");
  a_busrst_drive: assert property (I_USB_BUS_RESET |=> O_RESET_LINE_OE[*2])
    else $error("reset line not driven during bus reset");
  a_soft_drive: assert property (soft_rst_r |-> ##2 O_RESET_LINE_OE)
    else $error("soft reset did not drive reset line");
  a_ext_detect: assert property (ext_det_r |-> ##2 O_RESET_LINE_OE)
    else $error("external reset not honoured");
  a_stat_defaults: assert property ($fell(I_RESET) |-> stat1_pol_r && !stat2_pol_r
    && stat1_sel_r == 2'b01 && stat2_sel_r == 2'b01)
    else $error("status pin defaults wrong");
  a_pullup_off: assert property (self_pwr_r && !sync2_r[1] |=> !O_DP_PULLUP_EN)
    else $error("pull-up enabled without VBUS");
  a_nine_input: assert property (!cfg_rst && pin_func_r[0] |=> !O_GPIO_NINE_OE
    && O_SET_READY_N == $past(sync2_r[4]))
    else $error("pin nine not a set-ready input");
  a_eight_output: assert property (!cfg_rst && pin_func_r[1] |=> O_GPIO_EIGHT_OE
    && O_GPIO_EIGHT == $past(I_TERMINAL_READY_N))
    else $error("pin eight not driving terminal-ready");
  a_seven_default: assert property ($fell(I_RESET) |-> !O_GPIO_SEVEN_OE && O_GPIO_SEVEN_PULLUP)
    else $error("pin seven default wrong");
  a_seven_wake: assert property (!cfg_rst && g7_mode == 2'b10 |=> !O_GPIO_SEVEN_OE
    && O_REMOTE_WAKE_N == $past(sync2_r[2]) && O_RING_N)
    else $error("pin seven wake routing wrong");

  c_ext_reset: cover property (ext_det_r);
  c_soft_reset: cover property (soft_rst_r ##2 O_RESET_LINE_OE);
  c_read_status: cover property (I_ARVALID && arready_r && I_ARADDR == usb_pins_pkg::STATUS_OFS[ADDR_W-1:0]);
endmodule
`default_nettype wire

/* verification/usb_host_model.sv */
// Behavioural USB host and board model driving core state and the reset wire
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  // Clock and requests
  input wire logic i_clk,
  input wire logic [3:0] i_req,
  input wire logic i_pull,
  input wire logic i_line_oe,
  // Device side levels
  output logic [3:0] o_state,
  output wire logic o_line_n
);
  localparam int HOLD = usb_pins_pkg::EXT_RESET_MIN_CYC + 100;
  int cnt = 0;
  logic pull_r = 1'h0;
  // Host state bits: bus reset, suspend, configured, bus power
  initial o_state = 4'h8;
  always @(posedge i_clk) o_state <= i_req;
  // Board pull lasts well past the minimum so it always counts
  always @(posedge i_clk) begin
    if (i_pull && cnt == 0) cnt <= HOLD;
    else if (cnt != 0) cnt <= cnt - 1;
    pull_r <= (cnt > 1) || (i_pull && cnt == 0);
  end
  // Wire with weak pull-up
  assign o_line_n = !(i_line_oe || pull_r);
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Register-driven bench for the USB status and reset pin block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module tb_top;
  logic clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, arv = 1'h0, pull = 1'h0;
  logic g9 = 1'h1, g8 = 1'h1, g7 = 1'h1, tdr = 1'h1;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic [3:0] req = 4'h8;
  logic [1:0] resp;
  wire logic [3:0] st;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdw;
  wire logic awr, wr_r, bv, arr, rv, line_n, loe, s1, s2, pu, o9, oe9, dsr, o8, oe8, o7, oe7, pu7, ring, wake;
  wire logic core;
  int failures = 0, checks = 0;
  // Cfg, max power, host state, expected status drive
  localparam logic [16:0] TAB [12] = '{17'h06654, 17'h06651, 17'h0A651, 17'h0A654, 17'h0A670, 17'h0A679,
    17'h0A67C, 17'h04655, 17'h04650, 17'h0E655, 17'h02652, 17'h02651};
  always #5 clk = !clk;
  usb_host_model HOST (.i_clk(clk), .i_req(req), .i_pull(pull), .i_line_oe(loe), .o_state(st), .o_line_n(line_n));
  usb_status_reset_pins DUT (.I_MCLK(clk), .I_RESET(rst), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr),
    .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wr_r), .O_BRESP(bresp), .O_BVALID(bv),
    .I_BREADY(1'h1), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdw), .O_RRESP(rresp),
    .O_RVALID(rv), .I_RREADY(1'h1), .I_USB_BUS_RESET(st[0]), .I_SUSPENDED(st[1]), .I_CONFIGURED(st[2]),
    .O_CORE_RESET(core), .I_RESET_LINE_N(line_n), .O_RESET_LINE_OE(loe), .O_BUS_STATUS_OE(s1),
    .O_SECOND_BUS_STATUS_OE(s2), .I_BUS_POWER_SENSE(st[3]), .O_DP_PULLUP_EN(pu),
    .I_GPIO_NINE(oe9 ? o9 : g9), .O_GPIO_NINE(o9), .O_GPIO_NINE_OE(oe9), .O_SET_READY_N(dsr),
    .I_GPIO_EIGHT(oe8 ? o8 : g8), .O_GPIO_EIGHT(o8), .O_GPIO_EIGHT_OE(oe8), .I_TERMINAL_READY_N(tdr),
    .I_GPIO_SEVEN(oe7 ? o7 : g7), .O_GPIO_SEVEN(o7), .O_GPIO_SEVEN_OE(oe7), .O_GPIO_SEVEN_PULLUP(pu7),
    .O_RING_N(ring), .O_REMOTE_WAKE_N(wake));
  // Closing report
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Write cycle: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic done;
    n = 0;
    done = 1'h0;
    awa <= a; wd <= d; awv <= 1'h1; wv <= 1'h1;
    while (!done) begin
      @(posedge clk); n++;
      if (awv && awr) awv <= 1'h0;
      if (wv && wr_r) wv <= 1'h0;
      if (bv) begin done = 1'h1; resp = bresp; end
      if (n > 200) begin failures++; print_verdict(); end
    end
  endtask
  // Read cycle
  task automatic rd(input logic [7:0] a);
    int n;
    logic done;
    n = 0;
    done = 1'h0;
    ara <= a; arv <= 1'h1;
    while (!done) begin
      @(posedge clk); n++;
      if (arv && arr) arv <= 1'h0;
      if (rv) begin done = 1'h1; rdata = rdw; resp = rresp; end
      if (n > 200) begin failures++; print_verdict(); end
    end
  endtask
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask
  // Bounded wait for the reset wire drive to reach a level
  task automatic wait_line(input logic v);
    int n;
    n = 0;
    while (loe !== v) begin
      @(posedge clk); n++;
      if (n > 2600) begin failures++; print_verdict(); end
    end
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    `CHK("line_por", 1'h1, loe)
    `CHK("core_por", 1'h1, core)
    `CHK("s1_por", 1'h1, s1)
    `CHK("s2_por", 1'h0, s2)
    rst <= 1'h0;
    wait_line(1'h0);
    rd(8'h00); `CHK("stat1_cfg", 32'h3, rdata)
    rd(8'h04); `CHK("stat2_cfg", 32'h2, rdata)
    rd(8'h0C); `CHK("pin_func", 32'h430, rdata)
    `CHK("oe9", 1'h1, oe9)
    `CHK("oe8", 1'h1, oe8)
    `CHK("oe7", 1'h0, oe7)
    `CHK("pu7", 1'h1, pu7)
    `CHK("s1_idle", 1'h1, s1)
    `CHK("s2_idle", 1'h0, s2)
    req <= 4'hA; settle();
    `CHK("s1_susp", 1'h0, s1)
    `CHK("s2_susp", 1'h1, s2)
    rd(8'h10); `CHK("status", 32'h39A, rdata)
    $display("test defaults done");
    foreach (TAB[i]) begin
      wr(8'h00, {29'h0, TAB[i][15:13]});
      wr(8'h04, {29'h0, TAB[i][15:13]});
      wr(8'h08, {24'h0, TAB[i][12:5]});
      req <= TAB[i][4:1]; settle();
      `CHK("stat1_sel", TAB[i][0], s1)
      `CHK("stat2_sel", TAB[i][0], s2)
    end
    wait_line(1'h0);
    $display("test status select done");
    wr(8'h08, 32'h132); req <= 4'h0; settle();
    `CHK("pullup_novbus", 1'h0, pu)
    req <= 4'h8; settle();
    `CHK("pullup_vbus", 1'h1, pu)
    wr(8'h0C, 32'h437);
    for (int v = 0; v < 2; v++) begin
      g9 <= v[0]; g7 <= v[0]; tdr <= v[0]; settle();
      `CHK("set_ready", v[0], dsr)
      `CHK("term_ready", v[0], o8)
      `CHK("term_oe", 1'h1, oe8)
      `CHK("ring", v[0], ring)
    end
    wr(8'h0C, 32'h438); g7 <= 1'h0; settle();
    `CHK("wake", 1'h0, wake)
    wr(8'h0C, 32'h7F0); settle();
    `CHK("gpio9_out", 1'h1, o9)
    `CHK("gpio8_out", 1'h1, o8)
    `CHK("gpio7_oe", 1'h1, oe7)
    `CHK("gpio7_out", 1'h1, o7)
    $display("test power and modem done");
    wr(8'h14, 32'h1); settle();
    `CHK("line_soft", 1'h1, loe)
    `CHK("core_soft", 1'h1, core)
    wait_line(1'h0);
    pull <= 1'h1; @(posedge clk); pull <= 1'h0;
    wait_line(1'h1);
    `CHK("line_ext", 1'h1, loe)
    wait_line(1'h0);
    rd(8'h20); `CHK("unmapped", usb_pins_pkg::RESP_SLVERR, resp)
    wr(8'h10, 32'hFFFFFFFF); `CHK("ro_write", usb_pins_pkg::RESP_OKAY, resp)
    $display("test resets and bus errors done");
    print_verdict();
  end
endmodule
`default_nettype wire
